// File: include/dpo_pkg.sv
package dpo_pkg;
  // channel count and counter width
  localparam int NCH = 8;
  localparam int CW = 16;
  // bus regions, selected by paddr[7:5]
  localparam logic [2:0] R_MISC = 3'h0;
  localparam logic [2:0] R_CFG = 3'h1;
  localparam logic [2:0] R_SET = 3'h2;
  localparam logic [2:0] R_VAL = 3'h3;
  // word index inside the misc region, paddr[4:2]
  localparam logic [2:0] I_LEVEL = 3'h0;
  localparam logic [2:0] I_TRIG = 3'h1;
  localparam logic [2:0] I_GROUP = 3'h2;
  // channel config fields
  localparam int CFG_W = 6;
  localparam int CFG_FN_LSB = 0;
  localparam int CFG_FN_MSB = 2;
  localparam int CFG_WM = 3;
  localparam int CFG_FMB = 4;
  localparam int CFG_ACT = 5;
  // static function, driven high output type; function codes 4 to 7 leave the pin low
  localparam logic [CFG_W-1:0] CFG_RST = 6'h20;
  localparam logic [CW-1:0] CNT_RST = 16'h0000;

  typedef enum logic [2:0] {FN_STATIC, FN_SINGLE, FN_PULSE, FN_SQUARE} dpo_fn_type;

  typedef struct packed {
    logic busy;
    logic [CW-1:0] cnt;
    logic [CW-1:0] per;
    logic [CW-1:0] wid;
  } dpo_chan_type;

  typedef struct packed {
    logic [NCH-1:0] dout;
    logic [NCH-1:0] oe;
  } dpo_pins_type;
endpackage

// File: rtl/dpo_top.sv
// Our own choices: the APB interface to the registers and the address map.
module dpo_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output dpo_pkg::dpo_pins_type pins
);
  import dpo_pkg::*;

  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [NCH-1:0] stat_q, stat_d, trig_q, trig_d, lvl_q, lvl_d, busy_v;
  logic grp_q, grp_d;
  logic [CFG_W-1:0] cfg_q [NCH], cfg_d [NCH];
  logic [CW-1:0] set_q [NCH], set_d [NCH], val_q [NCH], val_d [NCH];
  dpo_chan_type st_q [NCH], st_d [NCH];
  dpo_pins_type pins_q, pins_d;
  logic setup, wr, hit;
  logic [2:0] idx;
  logic [31:0] rdat;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pins = pins_q;
  assign idx = paddr[4:2];
  assign setup = psel & ~penable;
  // pready is only high in the access phase, so this is the one commit edge
  assign wr = psel & penable & pwrite & pready_q & ~pslverr_q;

  // apb decode: data captured in setup, one wait-free access phase
  always_comb begin
    hit = 1'b1;
    rdat = 32'h0000_0000;
    case (paddr[7:5])
      R_MISC: begin
        case (idx)
          I_LEVEL: rdat = {16'h0000, lvl_q, stat_q};
          I_TRIG: rdat = {24'h00_0000, busy_v};
          I_GROUP: rdat = {31'h0, grp_q};
          default: hit = 1'b0;
        endcase
      end
      R_CFG: rdat = {26'h0, cfg_q[idx]};
      R_SET: rdat = {16'h0000, set_q[idx]};
      R_VAL: rdat = {16'h0000, val_q[idx]};
      default: hit = 1'b0;
    endcase
    prdata_d = setup ? (hit ? rdat : 32'h0000_0000) : prdata_q;
    pready_d = setup;
    pslverr_d = setup & ~hit;
  end

  // register writes; a trigger write is a one-cycle pulse per channel
  always_comb begin
    stat_d = stat_q;
    grp_d = grp_q;
    cfg_d = cfg_q;
    set_d = set_q;
    val_d = val_q;
    trig_d = '0;
    if (wr) begin
      case (paddr[7:5])
        R_MISC: begin
          case (idx)
            I_LEVEL: stat_d = pwdata[NCH-1:0];
            I_TRIG: trig_d = pwdata[NCH-1:0];
            I_GROUP: grp_d = pwdata[0];
            default: grp_d = grp_q;
          endcase
        end
        R_CFG: cfg_d[idx] = pwdata[CFG_W-1:0];
        R_SET: set_d[idx] = pwdata[CW-1:0];
        R_VAL: val_d[idx] = pwdata[CW-1:0];
        default: grp_d = grp_q;
      endcase
    end
  end

  // channel generators; period and width are latched only at a boundary
  always_comb begin
    logic [CFG_W-1:0] c;
    dpo_fn_type fn;
    logic [CW-1:0] p_sel, w_sel;
    logic bnd;
    c = '0;
    fn = FN_STATIC;
    p_sel = '0;
    w_sel = '0;
    bnd = 1'b0;
    for (int i = 0; i < NCH; i++) begin
      c = grp_q ? cfg_q[0] : cfg_q[i];
      fn = dpo_fn_type'(c[CFG_FN_MSB:CFG_FN_LSB]);
      busy_v[i] = st_q[i].busy;
      st_d[i] = st_q[i];
      bnd = ~st_q[i].busy | (({1'b0, st_q[i].cnt} + 17'h0_0001) >= {1'b0, st_q[i].per});
      if (fn == FN_SQUARE) begin
        p_sel = val_q[i];
        w_sel = {1'b0, val_q[i][CW-1:1]};
      end else if (c[CFG_WM]) begin
        p_sel = set_q[i];
        w_sel = val_q[i];
      end else begin
        p_sel = val_q[i];
        w_sel = set_q[i];
      end
      case (fn)
        FN_SINGLE: begin
          if (!st_q[i].busy) begin
            // a trigger during a pulse is ignored: one pulse per trigger
            if (trig_q[i] && val_q[i] != CNT_RST) begin
              st_d[i].busy = 1'b1;
              st_d[i].cnt = CNT_RST;
              st_d[i].wid = val_q[i];
            end
          end else if (({1'b0, st_q[i].cnt} + 17'h0_0001) >= {1'b0, st_q[i].wid}) begin
            st_d[i].busy = 1'b0;
          end else begin
            st_d[i].cnt = st_q[i].cnt + 16'h0001;
          end
        end
        FN_PULSE, FN_SQUARE: begin
          if (bnd) begin
            st_d[i].cnt = CNT_RST;
            st_d[i].per = p_sel;
            st_d[i].wid = w_sel;
            st_d[i].busy = (p_sel != CNT_RST);
          end else begin
            st_d[i].cnt = st_q[i].cnt + 16'h0001;
          end
        end
        default: begin
          st_d[i].busy = 1'b0;
          st_d[i].cnt = CNT_RST;
        end
      endcase
      if (fn == FN_STATIC) begin
        lvl_d[i] = stat_q[i];
      end else begin
        lvl_d[i] = st_d[i].busy & (st_d[i].cnt < st_d[i].wid);
      end
      // passive type only pulls low; the high level comes from the pull-up
      pins_d.dout[i] = c[CFG_ACT] & lvl_d[i];
      pins_d.oe[i] = c[CFG_ACT] | ~lvl_d[i];
    end
  end

  // state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      stat_q <= '0;
      trig_q <= '0;
      lvl_q <= '0;
      grp_q <= 1'b0;
      pins_q <= '{dout: 8'h00, oe: 8'hff};
      for (int i = 0; i < NCH; i++) begin
        cfg_q[i] <= CFG_RST;
        set_q[i] <= CNT_RST;
        val_q[i] <= CNT_RST;
        st_q[i] <= '0;
      end
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      stat_q <= stat_d;
      trig_q <= trig_d;
      lvl_q <= lvl_d;
      grp_q <= grp_d;
      pins_q <= pins_d;
      cfg_q <= cfg_d;
      set_q <= set_d;
      val_q <= val_d;
      st_q <= st_d;
    end
  end

  // checking helpers on channel 0: high run length and rise-to-rise spacing
  dpo_fn_type fn0;
  logic lvl_p, seen_q;
  logic [CW-1:0] hi_n, rr_n;
  logic rose0;
  assign fn0 = dpo_fn_type'(cfg_q[0][CFG_FN_MSB:CFG_FN_LSB]);
  assign rose0 = lvl_q[0] & ~lvl_p;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl_p <= 1'b0;
      seen_q <= 1'b0;
      hi_n <= CNT_RST;
      rr_n <= CNT_RST;
    end else begin
      lvl_p <= lvl_q[0];
      seen_q <= (seen_q | rose0) & (fn0 == FN_PULSE);
      hi_n <= lvl_q[0] ? hi_n + 16'h0001 : CNT_RST;
      rr_n <= rose0 ? 16'h0001 : rr_n + 16'h0001;
    end
  end

  property p_static;
    @(posedge pclk) disable iff (!presetn)
    (fn0 == FN_STATIC) && !grp_q |=> lvl_q[0] == $past(stat_q[0]);
  endproperty
  a_static: assert property (p_static) else $error("static level not held");

  property p_single_cause;
    @(posedge pclk) disable iff (!presetn)
    rose0 && (fn0 == FN_SINGLE) && !grp_q |-> $past(trig_q[0]);
  endproperty
  a_single_cause: assert property (p_single_cause) else $error("pulse without trigger");

  property p_single_width;
    @(posedge pclk) disable iff (!presetn)
    $fell(lvl_q[0]) && (fn0 == FN_SINGLE) && !grp_q |-> hi_n == st_q[0].wid;
  endproperty
  a_single_width: assert property (p_single_width) else $error("single pulse width wrong");

  property p_pwm_period;
    @(posedge pclk) disable iff (!presetn)
    rose0 && seen_q && (fn0 == FN_PULSE) && cfg_q[0][CFG_WM] && !grp_q
      |-> rr_n == $past(st_q[0].per);
  endproperty
  a_pwm_period: assert property (p_pwm_period) else $error("pwm period wrong");

  property p_pwm_width;
    @(posedge pclk) disable iff (!presetn)
    (fn0 == FN_PULSE) && cfg_q[0][CFG_WM] && !grp_q && $past(fn0 == FN_PULSE)
      && $stable(cfg_q[0]) && st_q[0].busy && st_q[0].cnt == CNT_RST
      |-> st_q[0].wid == $past(val_q[0]);
  endproperty
  a_pwm_width: assert property (p_pwm_width) else $error("pwm width not from value");

  property p_fm_width;
    @(posedge pclk) disable iff (!presetn)
    $fell(lvl_q[0]) && (fn0 == FN_PULSE) && !cfg_q[0][CFG_WM] && !grp_q
      |-> hi_n == st_q[0].wid;
  endproperty
  a_fm_width: assert property (p_fm_width) else $error("fm width wrong");

  property p_fm_period;
    @(posedge pclk) disable iff (!presetn)
    (fn0 == FN_PULSE) && !cfg_q[0][CFG_WM] && !grp_q && $past(fn0 == FN_PULSE)
      && $stable(cfg_q[0]) && st_q[0].busy && st_q[0].cnt == CNT_RST
      |-> st_q[0].per == $past(val_q[0]);
  endproperty
  a_fm_period: assert property (p_fm_period) else $error("fm period not from value");

  property p_square;
    @(posedge pclk) disable iff (!presetn)
    (fn0 == FN_SQUARE) && !grp_q && $past(fn0 == FN_SQUARE) && st_q[0].busy
      && st_q[0].cnt == CNT_RST |-> st_q[0].per == $past(val_q[0])
      && st_q[0].wid == {1'b0, st_q[0].per[CW-1:1]};
  endproperty
  a_square: assert property (p_square) else $error("square period wrong");

  property p_passive;
    @(posedge pclk) disable iff (!presetn)
    !cfg_q[0][CFG_ACT] && !grp_q |=> !pins_q.dout[0] && pins_q.oe[0] == !lvl_q[0];
  endproperty
  a_passive: assert property (p_passive) else $error("passive pin drives high");

  property p_no_runt;
    @(posedge pclk) disable iff (!presetn)
    (fn0 == FN_PULSE) && !grp_q && st_q[0].busy
      && ({1'b0, st_q[0].cnt} + 17'h0_0002) <= {1'b0, st_q[0].per}
      |=> $stable(st_q[0].wid) && $stable(st_q[0].per);
  endproperty
  a_no_runt: assert property (p_no_runt) else $error("timing changed mid period");

  c_single: cover property (@(posedge pclk) disable iff (!presetn)
    (fn0 == FN_SINGLE) && $fell(lvl_q[0]));
  c_pwm: cover property (@(posedge pclk) disable iff (!presetn)
    rose0 && seen_q && cfg_q[0][CFG_WM]);
  c_fm: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(lvl_q[0]) && (fn0 == FN_PULSE) && !cfg_q[0][CFG_WM]);
  c_square: cover property (@(posedge pclk) disable iff (!presetn)
    (fn0 == FN_SQUARE) && rose0);
endmodule

// File: tb/dpo_load.sv
module dpo_load (
  input wire dpo_pkg::dpo_pins_type pins,
  output logic [dpo_pkg::NCH-1:0] level
);
  timeunit 1ns;
  timeprecision 100ps;
  import dpo_pkg::*;
  // undriven pins float up to the pull-up resistor
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      level[i] = pins.oe[i] ? pins.dout[i] : 1'b1;
    end
  end
endmodule

// File: tb/dpo_top_tb.sv
module dpo_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dpo_pkg::*;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  dpo_pins_type pins;
  logic [NCH-1:0] level;
  logic [31:0] rd;
  logic er;
  int bad_count = 0;
  int checks = 0;
  dpo_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins));
  dpo_load load (.pins(pins), .level(level));
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  task close_out();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one apb transfer; ready, data and error are taken at the edge that ends the access
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      bad_count++;
      $display("CHECK FAILED t=%0t no pready", $time);
      close_out();
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp, "read");
    chk({31'h0, er}, 32'h0, "slverr");
  endtask
  // counts high samples over n cycles and rising edges over n transitions
  task pulse_chk(input int ch, input int n, input int settle, input int e1, input int er1);
    logic prev;
    int ones;
    int rises;
    ones = 0;
    rises = 0;
    repeat (settle) @(posedge pclk);
    @(negedge pclk);
    prev = level[ch];
    for (int i = 0; i < n; i++) begin
      if (prev === 1'b1) ones++;
      @(negedge pclk);
      if (prev === 1'b0 && level[ch] === 1'b1) rises++;
      prev = level[ch];
    end
    chk(32'(ones), 32'(e1), "high cycles");
    chk(32'(rises), 32'(er1), "rising edges");
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(8'h20, 32'h20);
    chk({24'h0, pins.oe}, 32'hff, "reset oe");
    // static levels stand until rewritten
    wr(8'h00, 32'ha5);
    rd_chk(8'h00, 32'ha5a5);
    chk({24'h0, level}, 32'ha5, "static level");
    wr(8'h24, 32'h00);
    wr(8'h00, 32'ha7);
    // pins follow the written state one cycle after the commit edge
    repeat (2) @(posedge pclk);
    chk({31'h0, pins.oe[1]}, 32'h0, "passive high");
    chk({24'h0, level}, 32'ha7, "pulled level");
    // group mode: channel 0 config governs all eight bits
    wr(8'h08, 32'h1);
    wr(8'h20, 32'h00);
    repeat (2) @(posedge pclk);
    chk({24'h0, pins.oe}, 32'h58, "group passive");
    // channel 0 stays passive for a few cycles with group mode off
    wr(8'h08, 32'h0);
    wr(8'h20, 32'h20);
    wr(8'h24, 32'h20);
    wr(8'h00, 32'h00);
    // pulse modes run on channel 0, where the checkers watch
    // single pulse, second trigger lands while busy
    wr(8'h20, 32'h21);
    wr(8'h60, 32'h5);
    fork
      pulse_chk(0, 24, 0, 5, 1);
      begin
        wr(8'h04, 32'h1);
        wr(8'h04, 32'h1);
      end
    join
    // pwm: flag and period set while static, then the pulse function
    wr(8'h20, 32'h28);
    wr(8'h40, 32'h4);
    wr(8'h60, 32'h1);
    wr(8'h20, 32'h2a);
    pulse_chk(0, 16, 8, 4, 4);
    wr(8'h60, 32'h3);
    pulse_chk(0, 16, 8, 12, 4);
    // fm: fixed width 2, period 8 then 4
    wr(8'h20, 32'h30);
    wr(8'h40, 32'h2);
    wr(8'h60, 32'h8);
    wr(8'h20, 32'h32);
    pulse_chk(0, 16, 8, 4, 2);
    wr(8'h60, 32'h4);
    pulse_chk(0, 16, 8, 8, 4);
    // square wave, period 8, entered from static
    wr(8'h20, 32'h20);
    wr(8'h60, 32'h8);
    wr(8'h20, 32'h23);
    pulse_chk(0, 16, 8, 8, 2);
    // unmapped place refuses
    wr(8'he0, 32'h1);
    chk({31'h0, er}, 32'h1, "unmapped write");
    apb(1'b0, 8'he0, 32'h0);
    chk(rd, 32'h0, "unmapped data");
    chk({31'h0, er}, 32'h1, "unmapped read");
    close_out();
  end
endmodule
